// ---- i2c_regs_pkg.sv ----
// register map, field layout and reset values of the address/interrupt/status bank
// Notes on behaviour
// - 10-bit own address at offset 0, resets zero
// - respond as target only on address match
// - 7-bit mode compares bits 6-0 only
// - 10-bit mode compares all ten bits
// - reserved bits read zero, writes ignored
// - seven enables at bits 6-0, reset zero
// - six W1C flags bits 5-0, tx ready resets one
// - read-only bits 11-8, W1C bits 14-12
// - writing one clears, zero leaves unchanged
// - bus busy clears on stop or W1C
package i2c_regs_pkg;
	localparam int         PADDR_W        = 8;
	localparam int         OWN_ADDR_W     = 10;
	localparam int         IER_W          = 7;
	localparam int         W1C_N          = 9;
	localparam logic [7:0] OFS_OWN_ADDR   = 8'h00;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h04;
	localparam logic [7:0] OFS_STATUS     = 8'h08;
	// status word bit positions
	localparam int         BIT_ADDR_TGT   = 9;
	localparam int         BIT_GEN_CALL   = 8;
	localparam int         BIT_TX_EMPTY   = 10;
	localparam int         BIT_RX_OVR     = 11;
	localparam int         BIT_BUS_BUSY   = 12;
	localparam int         BIT_NOACK_SENT = 13;
	localparam int         BIT_TGT_TX_DIR = 14;
	// w1c vector: [5:0] are status 5..0; [8:6] are bus busy, noack sent, target tx dir
	localparam int         W1C_LO_N       = 6;
	localparam int         W1C_HI_POS     = 12;
	localparam int         IER_ADDR_TGT   = 6;
	localparam int         IDX_BUS_BUSY   = 8;
	localparam int         IDX_NOACK_SENT = 7;
	localparam int         IDX_TGT_TX_DIR = 6;
	localparam logic [9:0] OWN_ADDR_RST   = 10'h000;
	localparam logic [6:0] IER_RST        = 7'h00;
	localparam logic [8:0] W1C_RST        = 9'h010;
	localparam logic       TX_EMPTY_RST   = 1'b1;
	typedef enum logic [1:0] {SEL_OWN, SEL_IER, SEL_STS, SEL_NONE} reg_sel_t;
endpackage

// ---- addr_match_if.sv ----
// own-address comparison signals between the register bank and the matcher
`timescale 1ns/1ps
interface addr_match_if;
	logic [9:0] own_addr;
	logic       ten_bit;
	logic [9:0] rx_addr;
	logic       match;
	modport bank    (output own_addr, output ten_bit, output rx_addr, input match);
	modport matcher (input own_addr, input ten_bit, input rx_addr, output match);
endinterface

// ---- addr_matcher.sv ----
// own-address comparator for 7-bit and 10-bit addressing
`timescale 1ns/1ps
module addr_matcher
(
	addr_match_if.matcher m
);
	always_comb
	begin
		if (m.ten_bit)
			m.match = (m.rx_addr == m.own_addr);
		else
			m.match = (m.rx_addr[6:0] == m.own_addr[6:0]);
	end
endmodule // addr_matcher

// ---- i2c_addr_irq_status_regs.sv ----
// own-address, interrupt-enable and status registers with APB slave and irq
`timescale 1ns/1ps
module i2c_addr_irq_status_regs
(
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [i2c_regs_pkg::PADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      module_reset,
	input  wire logic                      ten_bit_addr_select,
	input  wire logic [i2c_regs_pkg::OWN_ADDR_W-1:0] rx_addr,
	input  wire logic                      rx_addr_valid,
	input  wire logic                      start_evt,
	input  wire logic                      stop_evt,
	input  wire logic                      tx_ready_evt,
	input  wire logic                      rx_ready_evt,
	input  wire logic                      reg_access_ready_evt,
	input  wire logic                      noack_evt,
	input  wire logic                      arb_lost_evt,
	input  wire logic                      target_tx_dir_evt,
	input  wire logic                      noack_sent_evt,
	input  wire logic                      bus_busy_evt,
	input  wire logic                      rx_shift_overrun,
	input  wire logic                      tx_shift_empty,
	input  wire logic                      general_call_detected,
	output logic [i2c_regs_pkg::OWN_ADDR_W-1:0] own_target_addr_field,
	output logic                           addressed_as_target,
	output logic                           irq
);
	import i2c_regs_pkg::*;

	logic [OWN_ADDR_W-1:0] own_addr_r;
	logic [IER_W-1:0]      ier_r;
	logic [W1C_N-1:0]      w1c_r;
	logic [W1C_N-1:0]      w1c_set;
	logic [W1C_N-1:0]      w1c_hwclr;
	logic [W1C_N-1:0]      w1c_swclr;
	logic                  addr_tgt_r;
	logic                  rx_ovr_r;
	logic                  tx_empty_r;
	logic                  gen_call_r;
	logic [31:0]           prdata_r;
	logic                  pready_r;
	logic                  pslverr_r;
	logic                  irq_r;
	logic [OWN_ADDR_W-1:0] own_out_r;
	logic               setup_ph;
	logic               wr_en;
	logic [IER_W-1:0]   pending;
	logic [31:0]        status_word;
	logic [31:0]        rd_nxt;

	addr_match_if am ();

	addr_matcher u_match
	(
		.m (am.matcher)
	);

	function automatic reg_sel_t decode(input logic [PADDR_W-1:0] a);
		case (a)
			OFS_OWN_ADDR: decode = SEL_OWN;
			OFS_IRQ_EN:   decode = SEL_IER;
			OFS_STATUS:   decode = SEL_STS;
			default:      decode = SEL_NONE;
		endcase
	endfunction

	assign am.own_addr = own_addr_r;
	assign am.ten_bit  = ten_bit_addr_select;
	assign am.rx_addr  = rx_addr;

	// zero-wait slave: read data is captured in setup, writes land in the access cycle, pready high in the access cycle
	assign setup_ph = psel && !penable;
	assign wr_en    = psel && penable && pready_r && pwrite;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r  <= setup_ph;
			pslverr_r <= setup_ph && (decode(paddr) == SEL_NONE);
		end
	end

	// reserved bits sit as constant zeros in the read word
	// bus busy sits at bit 12 and target direction at bit 14, the reverse of their vector order
	assign status_word = {17'h0, w1c_r[IDX_TGT_TX_DIR], w1c_r[IDX_NOACK_SENT], w1c_r[IDX_BUS_BUSY],
		rx_ovr_r, tx_empty_r, addr_tgt_r, gen_call_r, 2'b00, w1c_r[W1C_LO_N-1:0]};

	always_comb
	begin
		case (decode(paddr))
			SEL_OWN: rd_nxt = {22'h0, own_addr_r};
			SEL_IER: rd_nxt = {25'h0, ier_r};
			SEL_STS: rd_nxt = status_word;
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0000_0000;
		else if (setup_ph && !pwrite)
			prdata_r <= rd_nxt;
	end

	property p_reserved_ier;
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && paddr == OFS_IRQ_EN) |=> (prdata[31:IER_W] == 25'h0);
	endproperty
	a_reserved_ier: assert property (p_reserved_ier) else $error("reserved enable bits not zero");

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			own_addr_r <= OWN_ADDR_RST;
		else if (module_reset)
			own_addr_r <= OWN_ADDR_RST;
		else if (wr_en && decode(paddr) == SEL_OWN)
			own_addr_r <= pwdata[OWN_ADDR_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ier_r <= IER_RST;
		else if (module_reset)
			ier_r <= IER_RST;
		else if (wr_en && decode(paddr) == SEL_IER)
			ier_r <= pwdata[IER_W-1:0];
	end

	property p_mod_reset;
		@(posedge pclk) disable iff (!presetn)
		module_reset |=> (own_addr_r == OWN_ADDR_RST && ier_r == IER_RST && w1c_r == W1C_RST);
	endproperty
	a_mod_reset: assert property (p_mod_reset) else $error("module reset left state behind");

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			addr_tgt_r <= 1'b0;
		else if (module_reset || stop_evt)
			addr_tgt_r <= 1'b0;
		else if (rx_addr_valid)
			addr_tgt_r <= am.match;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_ovr_r   <= 1'b0;
			tx_empty_r <= TX_EMPTY_RST;
			gen_call_r <= 1'b0;
		end
		else if (module_reset)
		begin
			rx_ovr_r   <= 1'b0;
			tx_empty_r <= TX_EMPTY_RST;
			gen_call_r <= 1'b0;
		end
		else
		begin
			rx_ovr_r   <= rx_shift_overrun;
			tx_empty_r <= tx_shift_empty;
			gen_call_r <= general_call_detected;
		end
	end

	assign w1c_set   = {bus_busy_evt, noack_sent_evt, target_tx_dir_evt, stop_evt, tx_ready_evt,
		rx_ready_evt, reg_access_ready_evt, noack_evt, arb_lost_evt};
	assign w1c_hwclr = {stop_evt, 1'b0, stop_evt || start_evt, 6'h00};
	assign w1c_swclr = (wr_en && decode(paddr) == SEL_STS) ?
		{pwdata[BIT_BUS_BUSY], pwdata[BIT_NOACK_SENT], pwdata[BIT_TGT_TX_DIR], pwdata[W1C_LO_N-1:0]} : 9'h000;

	// a new event beats a clear landing in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < W1C_N; gi++)
		begin : g_w1c
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					w1c_r[gi] <= W1C_RST[gi];
				else if (module_reset)
					w1c_r[gi] <= W1C_RST[gi];
				else if (w1c_set[gi])
					w1c_r[gi] <= 1'b1;
				else if (w1c_swclr[gi] || w1c_hwclr[gi])
					w1c_r[gi] <= 1'b0;
			end
		end
	endgenerate

	property p_start_clears;
		@(posedge pclk) disable iff (!presetn)
		(start_evt && !target_tx_dir_evt && !module_reset) |=> !status_word[BIT_TGT_TX_DIR];
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("target direction kept after start");

	property p_set_wins;
		@(posedge pclk) disable iff (!presetn)
		(arb_lost_evt && !module_reset) |=> w1c_r[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to a clear");

	property p_sw_clear_bb;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == OFS_STATUS && pwdata[BIT_BUS_BUSY] && !bus_busy_evt && !module_reset)
			|=> !status_word[BIT_BUS_BUSY];
	endproperty
	a_sw_clear_bb: assert property (p_sw_clear_bb) else $error("bus busy kept after write of one");

	assign pending = {addr_tgt_r, w1c_r[W1C_LO_N-1:0]} & ier_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_r     <= 1'b0;
			own_out_r <= OWN_ADDR_RST;
		end
		else
		begin
			irq_r     <= |pending;
			own_out_r <= own_addr_r;
		end
	end

	assign prdata                = prdata_r;
	assign pready                = pready_r;
	assign pslverr               = pslverr_r;
	assign irq                   = irq_r;
	assign own_target_addr_field = own_out_r;
	assign addressed_as_target   = addr_tgt_r;

	property p_own_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == OFS_OWN_ADDR && !module_reset) |=> (own_addr_r == $past(pwdata[9:0]));
	endproperty
	a_own_write: assert property (p_own_write) else $error("own address not stored");

	property p_match_sets;
		@(posedge pclk) disable iff (!presetn)
		(rx_addr_valid && !stop_evt && !module_reset) |=> (addr_tgt_r == $past(am.match));
	endproperty
	a_match_sets: assert property (p_match_sets) else $error("target flag disagrees with match");

	property p_seven_bit;
		@(posedge pclk) disable iff (!presetn)
		(!ten_bit_addr_select && rx_addr[6:0] == own_addr_r[6:0]) |-> am.match;
	endproperty
	a_seven_bit: assert property (p_seven_bit) else $error("7-bit compare missed");

	property p_ten_bit;
		@(posedge pclk) disable iff (!presetn)
		ten_bit_addr_select |-> (am.match == (rx_addr == own_addr_r));
	endproperty
	a_ten_bit: assert property (p_ten_bit) else $error("10-bit compare wrong");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && paddr == OFS_STATUS) |=> (prdata[31:15] == 17'h0 && prdata[7:6] == 2'b00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits not zero");

	property p_ier_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == OFS_IRQ_EN && !module_reset) |=> (ier_r == $past(pwdata[6:0]));
	endproperty
	a_ier_write: assert property (p_ier_write) else $error("enable write lost");

	property p_w1c_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == OFS_STATUS && pwdata[0] && !arb_lost_evt && !module_reset) |=> !w1c_r[0];
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("W1C did not clear");

	property p_zero_keeps;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == OFS_STATUS && !pwdata[1] && w1c_r[1] && !module_reset) |=> w1c_r[1];
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

	property p_bb_stop;
		@(posedge pclk) disable iff (!presetn)
		(stop_evt && !bus_busy_evt) |=> !w1c_r[IDX_BUS_BUSY] ##1 (status_word[BIT_BUS_BUSY] == w1c_r[IDX_BUS_BUSY]);
	endproperty
	a_bb_stop: assert property (p_bb_stop) else $error("bus busy kept after stop");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		(|pending) |=> irq ##1 (irq == $past(|pending));
	endproperty
	a_irq: assert property (p_irq) else $error("irq not following enabled flags");

	property p_irq_off;
		@(posedge pclk) disable iff (!presetn)
		!(|pending) |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq without an enabled flag");
endmodule // i2c_addr_irq_status_regs

// ---- testbench.sv ----
// self-checking bench for the own-address, interrupt-enable and status bank
`timescale 1ns/1ps
module testbench;
	import i2c_regs_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        mod_rst;
	logic        ten_sel;
	logic [9:0]  rx_addr;
	logic        rx_valid;
	logic [9:0]  evt;
	logic [2:0]  lvl;
	logic [9:0]  own_field;
	logic        aat;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          fails;
	int          checks_done;

	i2c_addr_irq_status_regs DUT
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .module_reset(mod_rst),
		.ten_bit_addr_select(ten_sel), .rx_addr(rx_addr), .rx_addr_valid(rx_valid),
		.arb_lost_evt(evt[0]), .noack_evt(evt[1]), .reg_access_ready_evt(evt[2]),
		.rx_ready_evt(evt[3]), .tx_ready_evt(evt[4]), .stop_evt(evt[5]),
		.target_tx_dir_evt(evt[6]), .noack_sent_evt(evt[7]), .bus_busy_evt(evt[8]),
		.start_evt(evt[9]), .rx_shift_overrun(lvl[0]), .tx_shift_empty(lvl[1]),
		.general_call_detected(lvl[2]), .own_target_addr_field(own_field),
		.addressed_as_target(aat), .irq(irq)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				fails++;
				complete_run();
			end
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic pulse(input logic [9:0] m);
		@(posedge pclk);
		evt <= m;
		@(posedge pclk);
		evt <= '0;
		tick(2);
	endtask

	task automatic addr_try(input logic ten, input logic [9:0] a, input logic exp);
		@(posedge pclk);
		ten_sel <= ten;
		rx_addr <= a;
		rx_valid <= 1'b1;
		@(posedge pclk);
		rx_valid <= 1'b0;
		tick(3);
		check({31'h0, aat}, {31'h0, exp});
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial
	begin
		fails = 0;
		checks_done = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mod_rst = 1'b0;
		ten_sel = 1'b0;
		rx_addr = 10'h000;
		rx_valid = 1'b0;
		evt = '0;
		lvl = 3'b010;
		tick(3);
		presetn <= 1'b1;
		rdchk(OFS_OWN_ADDR, 32'h0);
		check({31'h0, err}, 32'h0);
		rdchk(OFS_IRQ_EN, 32'h0);
		rdchk(OFS_STATUS, 32'h0000_0410);
		apb(1'b1, OFS_OWN_ADDR, 32'hffff_ffff);
		rdchk(OFS_OWN_ADDR, 32'h0000_03ff);
		check({22'h0, own_field}, 32'h0000_03ff);
		apb(1'b1, OFS_IRQ_EN, 32'hffff_ffff);
		rdchk(OFS_IRQ_EN, 32'h0000_007f);
		apb(1'b1, OFS_IRQ_EN, 32'h0);
		rdchk(8'h0c, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h0000_0410);
		rdchk(OFS_STATUS, 32'h0000_0400);
		pulse(10'h1df);
		apb(1'b1, OFS_STATUS, 32'h0);
		rdchk(OFS_STATUS, 32'h0000_741f);
		apb(1'b1, OFS_STATUS, 32'h0000_2005);
		rdchk(OFS_STATUS, 32'h0000_541a);
		pulse(10'h020);
		rdchk(OFS_STATUS, 32'h0000_043a);
		// set direction and busy together, then start clears only the direction at bit 14
		pulse(10'h140);
		rdchk(OFS_STATUS, 32'h0000_543a);
		pulse(10'h200);
		rdchk(OFS_STATUS, 32'h0000_143a);
		apb(1'b1, OFS_STATUS, 32'h0000_1000);
		rdchk(OFS_STATUS, 32'h0000_043a);
		apb(1'b1, OFS_STATUS, 32'hffff_ffff);
		rdchk(OFS_STATUS, 32'h0000_0400);
		// each enable gates only its own flag; stop pulse drives flag 5
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, OFS_IRQ_EN, 32'h1 << i);
			tick(3);
			check({31'h0, irq}, 32'h0);
			pulse(10'h1 << i);
			check({31'h0, irq}, 32'h1);
			apb(1'b1, OFS_IRQ_EN, 32'h0);
			tick(3);
			check({31'h0, irq}, 32'h0);
			apb(1'b1, OFS_IRQ_EN, 32'h1 << i);
			apb(1'b1, OFS_STATUS, 32'h1 << i);
			tick(3);
			check({31'h0, irq}, 32'h0);
		end
		apb(1'b1, OFS_OWN_ADDR, 32'h0000_03a5);
		apb(1'b1, OFS_IRQ_EN, 32'h0000_0040);
		addr_try(1'b0, 10'h125, 1'b1);
		check({31'h0, irq}, 32'h1);
		addr_try(1'b0, 10'h026, 1'b0);
		addr_try(1'b1, 10'h025, 1'b0);
		addr_try(1'b1, 10'h3a5, 1'b1);
		pulse(10'h020);
		check({31'h0, aat}, 32'h0);
		lvl <= 3'b101;
		apb(1'b1, OFS_STATUS, 32'hffff_ffff);
		apb(1'b1, OFS_STATUS, 32'h0000_0f00);
		rdchk(OFS_STATUS, 32'h0000_0900);
		lvl <= 3'b010;
		@(posedge pclk);
		mod_rst <= 1'b1;
		@(posedge pclk);
		mod_rst <= 1'b0;
		tick(3);
		rdchk(OFS_OWN_ADDR, 32'h0);
		rdchk(OFS_IRQ_EN, 32'h0);
		rdchk(OFS_STATUS, 32'h0000_0410);
		check({31'h0, irq}, 32'h0);
		complete_run();
	end
endmodule // testbench
